// ---- logic/ddc_cfg_defs.svh ----
// Register offsets, field positions, reset values and codes for the DDC config bank
`ifndef DDC_CFG_DEFS_SVH
`define DDC_CFG_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_DDC_CONTROL 12'h350
`define OFS_INPUT_ROUTE_AND_RATE 12'h351
`define OFS_OSC_CHANNEL_CONTROL 12'h354

// ****************************************************************
// Field positions
// ****************************************************************
`define DECIM_SEL_LSB 0
`define DECIM_SEL_MSB 2
`define C2R_BIT 3
`define I_ROUTE_BIT 0
`define Q_ROUTE_BIT 2
`define EXT_RATE_LSB 4
`define EXT_RATE_MSB 7
`define CHAN_SEL_LSB 0
`define CHAN_SEL_MSB 3
`define CHAN_MODE_LSB 4
`define CHAN_MODE_MSB 7

// Writable bit masks; all other bits are reserved
`define CONTROL_WMASK 8'h0f
`define ROUTE_WMASK 8'hf5
`define OSC_WMASK 8'hff

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CONTROL 8'h00
`define RST_ROUTE 8'h00
`define RST_OSC 8'h00
`define RST_COUNT 4'h0

// ****************************************************************
// Selector and rate codes
// ****************************************************************
`define DECIM_SEL_EXT 3'h7
`define EXT_RATE_THIRD_HALF4 4'h0
`define EXT_RATE_FIFTH_HALF1 4'h2
`define EXT_RATE_FIFTH_HALF2 4'h3
`define EXT_RATE_FIFTH_HALF3 4'h4

`endif

// ---- logic/ddc_cfg_pkg.sv ----
// Types shared by the DDC configuration bank
package ddc_cfg_pkg;

  typedef enum logic [3:0] {
    MODE_REGMAP = 4'h0,
    MODE_PIN_LEVEL = 4'h1,
    MODE_EDGE_A = 4'h8,
    MODE_EDGE_B = 4'ha
  } chan_mode_e;

  typedef logic [5:0] decim_t;
  typedef logic [3:0] chan_t;

endpackage : ddc_cfg_pkg

// ---- logic/pin_edge_sync.sv ----
// Two-flop synchroniser with rising-edge detect for one general purpose pin
`timescale 1ns/1ps
module pin_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;

endmodule : pin_edge_sync

// ---- logic/ddc_filter_input_nco_select.sv ----
// Second DDC channel: filter chain decode, input routing and oscillator channel select
//
// Function
// (R1) Selector 101: halfband one, two and third-order stage; decimate 6 or 12.
// (R2) Selector 110: halfband one to three and third-order stage; decimate 12 or 24.
// (R3) Selector 111: chain and factor come from the extended rate field.
// (R4) Extended rate field ignored unless selector is all ones.
// (R5) Extended code 0: third-order plus halfband four to one; 48 off, 24 on.
// (R6) Fifth-order codes 2, 3, 4 add halfbands; factors 10/5, 20/10, 40/20.
// (R7) Route bit 2 chooses Q input: 0 channel A, 1 channel B.
// (R8) Route bit 0 chooses I input: 0 channel A, 1 channel B.
// (R9) Mode 0: register map channel field is the oscillator channel.
// (R10) Mode 1: channel is zeros, pin B bit 0, pin A bit 0.
// (R11) Mode 1000: counter advances on pin A rising edge, drives channel.
// (R12) Mode 1010: counter advances on pin B rising edge, drives channel.
// (R13) Edge modes: counter wraps to zero after reaching channel field value.
// (R14) Channel field value picks oscillator channel 0 through 11 directly.
// (R15) Codes 12 through 15 select channels 12 through 15.
// (R16) Reserved bits read zero; writes to them are dropped.
// (R17) Reset clears all fields and the channel counter.
// (R18) Pins are synchronised before edge detection; one advance per edge.
`timescale 1ns/1ps
`include "ddc_cfg_defs.svh"
module ddc_filter_input_nco_select import ddc_cfg_pkg::*; #(
  parameter int ADDR_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  input wire logic PIN_A_BIT0,
  input wire logic PIN_B_BIT0,
  output logic HALFBAND_STAGE_ONE,
  output logic HALFBAND_STAGE_TWO,
  output logic HALFBAND_STAGE_THREE,
  output logic HALFBAND_STAGE_FOUR,
  output logic THIRD_ORDER_STAGE,
  output logic FIFTH_ORDER_STAGE,
  output logic [5:0] DECIM_FACTOR,
  output logic DECIM_INVALID,
  output logic I_FROM_CHAN_B,
  output logic Q_FROM_CHAN_B,
  output logic [3:0] OSC_CHANNEL
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W < 10 || ADDR_W > 12) begin : g_addr_w_check
    $error("ADDR_W must be 10 to 12 to reach the register offsets");
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] control_r;
  logic [7:0] route_r;
  logic [7:0] osc_r;
  logic [11:0] addr_full;
  logic hit_control;
  logic hit_route;
  logic hit_osc;

  assign addr_full = 12'(REG_ADDR);
  assign hit_control = (addr_full == `OFS_DDC_CONTROL);
  assign hit_route = (addr_full == `OFS_INPUT_ROUTE_AND_RATE);
  assign hit_osc = (addr_full == `OFS_OSC_CHANNEL_CONTROL);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      control_r <= `RST_CONTROL; // R17
      route_r <= `RST_ROUTE; // R17
      osc_r <= `RST_OSC; // R17
    end else if (REG_WR) begin
      if (hit_control) begin
        control_r <= REG_WDATA & `CONTROL_WMASK;
      end else if (hit_route) begin
        route_r <= REG_WDATA & `ROUTE_WMASK; // R16
      end else if (hit_osc) begin
        osc_r <= REG_WDATA & `OSC_WMASK;
      end
    end
  end

  // Registered read port: data one cycle after the address, zero off-map
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (hit_control) begin
      REG_RDATA <= control_r;
    end else if (hit_route) begin
      REG_RDATA <= route_r; // R16
    end else if (hit_osc) begin
      REG_RDATA <= osc_r;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  logic [2:0] decim_sel;
  logic c2r_on;
  logic [3:0] ext_rate;
  chan_t chan_field;
  chan_mode_e chan_mode;

  assign decim_sel = control_r[`DECIM_SEL_MSB:`DECIM_SEL_LSB];
  assign c2r_on = control_r[`C2R_BIT];
  assign ext_rate = route_r[`EXT_RATE_MSB:`EXT_RATE_LSB];
  assign chan_field = osc_r[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
  assign chan_mode = chan_mode_e'(osc_r[`CHAN_MODE_MSB:`CHAN_MODE_LSB]);

  // ****************************************************************
  // Filter chain decode
  // ****************************************************************
  logic stage_one_nxt;
  logic stage_two_nxt;
  logic stage_three_nxt;
  logic stage_four_nxt;
  logic tb_nxt;
  logic fb_nxt;
  decim_t base_nxt;
  decim_t factor_nxt;
  logic invalid_nxt;
  logic base_is_real;

  always_comb begin
    stage_one_nxt = 1'b0;
    stage_two_nxt = 1'b0;
    stage_three_nxt = 1'b0;
    stage_four_nxt = 1'b0;
    tb_nxt = 1'b0;
    fb_nxt = 1'b0;
    base_nxt = 6'h00;
    invalid_nxt = 1'b0;
    // Factors below are for complex-to-real on; doubled when off
    case (decim_sel)
      3'h0: begin
        stage_one_nxt = 1'b1;
        stage_two_nxt = 1'b1;
        base_nxt = 6'h02;
      end
      3'h1: begin
        stage_one_nxt = 1'b1;
        stage_two_nxt = 1'b1;
        stage_three_nxt = 1'b1;
        base_nxt = 6'h04;
      end
      3'h2: begin
        stage_one_nxt = 1'b1;
        stage_two_nxt = 1'b1;
        stage_three_nxt = 1'b1;
        stage_four_nxt = 1'b1;
        base_nxt = 6'h08;
      end
      3'h3: begin
        stage_one_nxt = 1'b1;
        base_nxt = 6'h01;
      end
      3'h4: begin
        stage_one_nxt = 1'b1;
        tb_nxt = 1'b1;
        base_nxt = 6'h03;
      end
      3'h5: begin
        stage_one_nxt = 1'b1; // R1
        stage_two_nxt = 1'b1; // R1
        tb_nxt = 1'b1; // R1
        base_nxt = 6'h06; // R1
      end
      3'h6: begin
        stage_one_nxt = 1'b1; // R2
        stage_two_nxt = 1'b1; // R2
        stage_three_nxt = 1'b1; // R2
        tb_nxt = 1'b1; // R2
        base_nxt = 6'h0c; // R2
      end
      default: begin
        // Extended field only consulted here
        case (ext_rate) // R3 R4
          `EXT_RATE_THIRD_HALF4: begin
            tb_nxt = 1'b1; // R5
            stage_four_nxt = 1'b1; // R5
            stage_three_nxt = 1'b1; // R5
            stage_two_nxt = 1'b1; // R5
            stage_one_nxt = 1'b1; // R5
            base_nxt = 6'h18; // R5
          end
          `EXT_RATE_FIFTH_HALF1: begin
            fb_nxt = 1'b1; // R6
            stage_one_nxt = 1'b1; // R6
            base_nxt = 6'h05; // R6
          end
          `EXT_RATE_FIFTH_HALF2: begin
            fb_nxt = 1'b1; // R6
            stage_two_nxt = 1'b1; // R6
            stage_one_nxt = 1'b1; // R6
            base_nxt = 6'h0a; // R6
          end
          `EXT_RATE_FIFTH_HALF3: begin
            fb_nxt = 1'b1; // R6
            stage_three_nxt = 1'b1; // R6
            stage_two_nxt = 1'b1; // R6
            stage_one_nxt = 1'b1; // R6
            base_nxt = 6'h14; // R6
          end
          default: begin
            // Undefined code: all stages idle rather than guess a chain
            invalid_nxt = 1'b1;
          end
        endcase
      end
    endcase
  end

  // Complex output needs twice the decimation of the real output
  assign base_is_real = c2r_on;
  assign factor_nxt = base_is_real ? base_nxt : decim_t'({base_nxt[4:0], 1'b0}); // R1 R2 R5 R6

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HALFBAND_STAGE_ONE <= 1'b0;
      HALFBAND_STAGE_TWO <= 1'b0;
      HALFBAND_STAGE_THREE <= 1'b0;
      HALFBAND_STAGE_FOUR <= 1'b0;
      THIRD_ORDER_STAGE <= 1'b0;
      FIFTH_ORDER_STAGE <= 1'b0;
      DECIM_FACTOR <= 6'h00;
      DECIM_INVALID <= 1'b0;
    end else begin
      HALFBAND_STAGE_ONE <= stage_one_nxt;
      HALFBAND_STAGE_TWO <= stage_two_nxt;
      HALFBAND_STAGE_THREE <= stage_three_nxt;
      HALFBAND_STAGE_FOUR <= stage_four_nxt;
      THIRD_ORDER_STAGE <= tb_nxt;
      FIFTH_ORDER_STAGE <= fb_nxt;
      DECIM_FACTOR <= factor_nxt;
      DECIM_INVALID <= invalid_nxt;
    end
  end

  // ****************************************************************
  // Input routing
  // ****************************************************************
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      I_FROM_CHAN_B <= 1'b0;
      Q_FROM_CHAN_B <= 1'b0;
    end else begin
      I_FROM_CHAN_B <= route_r[`I_ROUTE_BIT]; // R8
      Q_FROM_CHAN_B <= route_r[`Q_ROUTE_BIT]; // R7
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic pin_a_level;
  logic pin_a_rise;
  logic pin_b_level;
  logic pin_b_rise;

  // Pins may be asynchronous in practice; edges taken after two flops
  pin_edge_sync u_sync_a ( // R18
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pin(PIN_A_BIT0),
    .level(pin_a_level),
    .rise(pin_a_rise)
  );

  pin_edge_sync u_sync_b ( // R18
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .pin(PIN_B_BIT0),
    .level(pin_b_level),
    .rise(pin_b_rise)
  );

  // ****************************************************************
  // Edge-driven channel counter
  // ****************************************************************
  chan_t count_r;
  chan_t count_nxt;
  logic count_step;

  always_comb begin
    case (chan_mode)
      MODE_EDGE_A: count_step = pin_a_rise; // R11
      MODE_EDGE_B: count_step = pin_b_rise; // R12
      default: count_step = 1'b0;
    endcase
  end

  // Wraps at or beyond the limit so a lowered limit cannot strand the count
  assign count_nxt = (count_r >= chan_field) ? `RST_COUNT : chan_t'(count_r + 4'h1); // R13

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_r <= `RST_COUNT; // R17
    end else if (count_step) begin
      count_r <= count_nxt; // R11 R12
    end
  end

  // ****************************************************************
  // Oscillator channel select
  // ****************************************************************
  chan_t chan_nxt;

  always_comb begin
    case (chan_mode)
      MODE_REGMAP: chan_nxt = chan_field; // R9 R14 R15
      MODE_PIN_LEVEL: chan_nxt = {2'b00, pin_b_level, pin_a_level}; // R10
      MODE_EDGE_A: chan_nxt = count_r; // R11
      MODE_EDGE_B: chan_nxt = count_r; // R12
      // Undefined modes fall back to the register map field
      default: chan_nxt = chan_field;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OSC_CHANNEL <= 4'h0;
    end else begin
      OSC_CHANNEL <= chan_nxt;
    end
  end

endmodule : ddc_filter_input_nco_select

// ---- tb/ddc_cfg_props.sv ----
// Port-level assertions for the DDC configuration bank
`timescale 1ns/1ps
module ddc_cfg_props #(
  parameter int ADDR_W = 12
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic PIN_A_BIT0,
  input wire logic PIN_B_BIT0,
  input wire logic HALFBAND_STAGE_FOUR,
  input wire logic THIRD_ORDER_STAGE,
  input wire logic FIFTH_ORDER_STAGE,
  input wire logic [5:0] DECIM_FACTOR,
  input wire logic DECIM_INVALID,
  input wire logic I_FROM_CHAN_B,
  input wire logic Q_FROM_CHAN_B,
  input wire logic [3:0] OSC_CHANNEL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic wr_rt;
  logic wr_osc;
  assign wr_rt = REG_WR && REG_ADDR == 12'h351;
  assign wr_osc = REG_WR && REG_ADDR == 12'h354;

  invalid_clears_a: assert property (DECIM_INVALID |-> DECIM_FACTOR == 6'h00)
    else $error("invalid rate code with nonzero factor");
  fifth_alone_a: assert property (FIFTH_ORDER_STAGE |-> !THIRD_ORDER_STAGE)
    else $error("fifth and third order stages together");
  unmapped_zero_a: assert property
    (!($past(REG_ADDR) inside {12'h350, 12'h351, 12'h354}) |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property ($past(REG_ADDR) == 12'h351 |-> REG_RDATA[3] == 1'b0
    && REG_RDATA[1] == 1'b0) else $error("reserved route bits read nonzero");
  i_route_a: assert property (wr_rt ##1 !wr_rt |=> I_FROM_CHAN_B == $past(REG_WDATA[0], 2))
    else $error("I input route wrong");
  q_route_a: assert property (wr_rt ##1 !wr_rt |=> Q_FROM_CHAN_B == $past(REG_WDATA[2], 2))
    else $error("Q input route wrong");
  regmap_chan_a: assert property (wr_osc && REG_WDATA[7:4] == 4'h0 ##1 !wr_osc
    |=> OSC_CHANNEL == $past(REG_WDATA[3:0], 2)) else $error("register map channel wrong");
  level_high_a: assert property (wr_osc && REG_WDATA[7:4] == 4'h1 ##1 !wr_osc [*2]
    |=> OSC_CHANNEL[3:2] == 2'b00) else $error("pin level channel upper bits set");
  quiet_hold_a: assert property (($stable(PIN_A_BIT0) && $stable(PIN_B_BIT0)
    && !REG_WR) [*5] |-> $stable(OSC_CHANNEL)) else $error("channel moved without cause");

  cover property (DECIM_INVALID);
  cover property (FIFTH_ORDER_STAGE);
  cover property (!$stable(OSC_CHANNEL));
endmodule : ddc_cfg_props

bind ddc_filter_input_nco_select ddc_cfg_props #(.ADDR_W(ADDR_W)) u_ddc_cfg_props (
  .CORE_CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA, .PIN_A_BIT0, .PIN_B_BIT0,
  .HALFBAND_STAGE_FOUR, .THIRD_ORDER_STAGE, .FIFTH_ORDER_STAGE, .DECIM_FACTOR,
  .DECIM_INVALID, .I_FROM_CHAN_B, .Q_FROM_CHAN_B, .OSC_CHANNEL);

// ---- tb/ddc_filter_input_nco_select_tb_top.sv ----
// Self-checking testbench for the DDC configuration bank
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module ddc_filter_input_nco_select_tb_top;
  logic CORE_CLK = 1'b0;
  logic RESETN, REG_WR, PIN_A_BIT0, PIN_B_BIT0;
  logic [11:0] REG_ADDR;
  logic [7:0] REG_WDATA;
  wire [7:0] REG_RDATA;
  wire HALFBAND_STAGE_ONE, HALFBAND_STAGE_TWO, HALFBAND_STAGE_THREE, HALFBAND_STAGE_FOUR;
  wire THIRD_ORDER_STAGE, FIFTH_ORDER_STAGE, DECIM_INVALID, I_FROM_CHAN_B, Q_FROM_CHAN_B;
  wire [5:0] DECIM_FACTOR;
  wire [3:0] OSC_CHANNEL;
  wire [5:0] stg = {HALFBAND_STAGE_ONE, HALFBAND_STAGE_TWO, HALFBAND_STAGE_THREE,
    HALFBAND_STAGE_FOUR, THIRD_ORDER_STAGE, FIFTH_ORDER_STAGE};
  int fails = 0;
  int samples_checked = 0;

  ddc_filter_input_nco_select u_ddc_filter_input_nco_select (
    .CORE_CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA, .PIN_A_BIT0, .PIN_B_BIT0,
    .HALFBAND_STAGE_ONE, .HALFBAND_STAGE_TWO, .HALFBAND_STAGE_THREE, .HALFBAND_STAGE_FOUR,
    .THIRD_ORDER_STAGE, .FIFTH_ORDER_STAGE, .DECIM_FACTOR, .DECIM_INVALID,
    .I_FROM_CHAN_B, .Q_FROM_CHAN_B, .OSC_CHANNEL);

  always #50 CORE_CLK = ~CORE_CLK;

  // ****************************
  // Access tasks
  // ****************************
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    repeat (2) @(posedge CORE_CLK);
    #1;
    `CHK(REG_RDATA, exp)
  endtask : rd

  // Control then route write; outputs settle one edge after the registers
  task automatic dec(input logic [7:0] ctl, input logic [7:0] rt, input logic [5:0] st,
    input logic [5:0] fac);
    wr(12'h350, ctl);
    wr(12'h351, rt);
    repeat (3) @(posedge CORE_CLK);
    #1;
    `CHK(stg, st)
    `CHK(DECIM_FACTOR, fac)
    `CHK(DECIM_INVALID, fac == 6'h00)
    `CHK({Q_FROM_CHAN_B, I_FROM_CHAN_B}, {rt[2], rt[0]})
  endtask : dec

  task automatic osc(input logic [7:0] d, input logic [3:0] exp);
    wr(12'h354, d);
    repeat (3) @(posedge CORE_CLK);
    #1;
    `CHK(OSC_CHANNEL, exp)
  endtask : osc

  // Pin held high three cycles and low five so the synchroniser sees one clean edge
  task automatic pulse(input logic b, input logic [3:0] exp);
    @(posedge CORE_CLK);
    if (b) PIN_B_BIT0 <= 1'b1;
    else PIN_A_BIT0 <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    PIN_A_BIT0 <= 1'b0;
    PIN_B_BIT0 <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    #1;
    `CHK(OSC_CHANNEL, exp)
  endtask : pulse

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // ****************************
  // Test sequence
  // ****************************
  initial begin
    RESETN = 1'b0;
    REG_ADDR = 12'h000;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    PIN_A_BIT0 = 1'b0;
    PIN_B_BIT0 = 1'b0;
    repeat (8) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(12'h350, 8'h00);
    rd(12'h351, 8'h00);
    rd(12'h354, 8'h00);
    wr(12'h350, 8'hff);
    rd(12'h350, 8'h0f);
    wr(12'h351, 8'hff);
    rd(12'h351, 8'hf5);
    wr(12'h352, 8'hff);
    rd(12'h352, 8'h00);
    dec(8'h05, 8'h40, 6'h32, 6'h0c);
    dec(8'h0d, 8'h01, 6'h32, 6'h06);
    dec(8'h06, 8'h04, 6'h3a, 6'h18);
    dec(8'h0e, 8'h05, 6'h3a, 6'h0c);
    dec(8'h07, 8'h00, 6'h3e, 6'h30);
    dec(8'h0f, 8'h00, 6'h3e, 6'h18);
    dec(8'h07, 8'h20, 6'h21, 6'h0a);
    dec(8'h0f, 8'h21, 6'h21, 6'h05);
    dec(8'h07, 8'h34, 6'h31, 6'h14);
    dec(8'h0f, 8'h30, 6'h31, 6'h0a);
    dec(8'h07, 8'h40, 6'h39, 6'h28);
    dec(8'h0f, 8'h45, 6'h39, 6'h14);
    dec(8'h07, 8'h50, 6'h00, 6'h00);
    osc(8'h0b, 4'hb);
    osc(8'h0c, 4'hc);
    osc(8'h0f, 4'hf);
    osc(8'h82, 4'h0);
    pulse(1'b0, 4'h1);
    pulse(1'b0, 4'h2);
    pulse(1'b0, 4'h0);
    osc(8'ha3, 4'h0);
    pulse(1'b1, 4'h1);
    pulse(1'b0, 4'h1);
    pulse(1'b1, 4'h2);
    pulse(1'b1, 4'h3);
    pulse(1'b1, 4'h0);
    // Leave the count nonzero so the mid-run reset has something to clear
    pulse(1'b1, 4'h1);
    osc(8'h1f, 4'h0);
    @(posedge CORE_CLK);
    PIN_A_BIT0 <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    #1;
    `CHK(OSC_CHANNEL, 4'h1)
    @(posedge CORE_CLK);
    PIN_B_BIT0 <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    #1;
    `CHK(OSC_CHANNEL, 4'h3)
    @(posedge CORE_CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(12'h354, 8'h00);
    `CHK(DECIM_FACTOR, 6'h04)
    `CHK(OSC_CHANNEL, 4'h0)
    osc(8'ha3, 4'h0);
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge CORE_CLK);
    fails++;
    report_and_stop();
  end
endmodule : ddc_filter_input_nco_select_tb_top
